// *** bfs_pkg.sv ***
package bfs_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int SW_PERIOD_NS    = 2000;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SW_PERIOD_CYC   = SW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OVL_ALLOW_CYC   = 256;
  localparam int OVL_TRIP_CYC    = 257;
  localparam int RETRY_K         = 2853934;
  localparam int CSS_PF_DEFAULT  = 10000;
  // Capacitance in pF times the factor gives picoseconds times 1e-6, so microseconds.
  // The product overflows 32 bits, hence the wide intermediate.
  localparam int RETRY_US        = int'((longint'(CSS_PF_DEFAULT) * RETRY_K) / 1_000_000);
  localparam int RETRY_CYC       = RETRY_US * (CLK_HZ / 1_000_000);
  localparam int SS_RAMP_PERIODS = 512;
  localparam int SYNC_STAGES     = 2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BFS_OFF,
    BFS_SOFTSTART,
    BFS_RUN,
    BFS_RETRY_CHECK,
    BFS_RETRY_OFF,
    BFS_THERMAL
  } bfs_state_t;

  // Comparator inputs, all active high.
  typedef struct packed {
    logic pk_reached;   // high-side current reached the error-signal level
    logic over_limit;   // high-side current at or above current_limit_level
    logic ls_reverse;   // low-side current reached zero (about to reverse)
    logic fb_low_fold;  // feedback_input below 0.734 V
    logic fb_short;     // feedback_input below 0.3 V
    logic fb_low_ok;    // feedback_input below 91 % of 0.8 V
    logic ss_at_start;  // enable/soft-start pin at or above 0.7 V
    logic temp_hot;     // junction above 150 C
    logic temp_cool;    // junction back at about 130 C
  } bfs_cmp_t;

  localparam int CMP_W = $bits(bfs_cmp_t);

  // Switch commands, high side and low side.
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } bfs_drive_t;

endpackage

// *** bfs_sync.sv ***
module bfs_sync #(
  parameter int W      = 1,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage_reg [STAGES];

  // ---------------------------------------------------------------------------
  // Shift chain
  // ---------------------------------------------------------------------------
  // Only the last stage is visible; earlier stages feed nothing else.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_reg[i] <= '0;
    end
    else
    begin
      stage_reg[0] <= d;
      for (int i = 1; i < STAGES; i++)
        stage_reg[i] <= stage_reg[i-1];
    end
  end

  assign q = stage_reg[STAGES-1];

endmodule

// *** bfs_sequencer.sv ***
// Contract
// - Each fixed switching period ends high-side conduction once the current reaches the set level.
// - Over the current limit the high-side goes off at once and the low-side holds to period end (here it turns off earlier if low-side current reaches zero).
// - While feedback is under 0.734 V in overload the switching frequency is halved.
// - Overload for up to 256 consecutive cycles starts no retry action.
// - Overload past 256 cycles runs a soft-start, then if still limiting idles for the retry time.
// - Feedback under 0.3 V before 256 overload cycles enters the retry sequence at once.
// - The retry off time equals soft-start capacitance times 2853934 seconds per farad.
// - Retry protection is disabled during start-up.
// - Soft-start holds the reference at zero until the pin reaches 0.7 V, then ramps it to 0.8 V.
// - After soft-start the enable/soft-start pin is clamped to 3.3 V (here ss_clamp is high in BFS_RUN only, not in BFS_RETRY_CHECK).
// - The open-drain output-ok pin is pulled low while feedback is under 91 % of 0.8 V.
// - Over 150 C the power stage stops, and it resumes at about 130 C.
// - Low-side current sensing stops the low-side before reverse current flows.
module bfs_sequencer
  import bfs_pkg::*;
#(
  parameter int RETRY_CYCLES = bfs_pkg::RETRY_CYC,
  parameter int SS_PERIODS   = bfs_pkg::SS_RAMP_PERIODS
) (
  // Clock and reset (enable pin together with supply_low_lockout)
  input  wire logic              clk,
  input  wire logic              rstn,
  // Comparators
  input  wire bfs_pkg::bfs_cmp_t cmp_in,
  // Switch drive
  output bfs_pkg::bfs_drive_t    drive,
  // Soft-start reference and pin clamp
  output logic [9:0]             ref_ramp,
  output logic                   ss_clamp,
  // Open-drain output_ok_flag
  output logic                   output_ok_flag_o,
  output logic                   output_ok_flag_oe,
  // Status
  output logic                   burst_retry_protection,
  output logic                   thermal_off
);

  import bfs_pkg::*;

  localparam logic [9:0]  REF_FULL = 10'h3ff;
  localparam logic [6:0]  PER_LAST = 7'(SW_PERIOD_CYC - 1);
  localparam logic [8:0]  OVL_MAX  = 9'(OVL_TRIP_CYC);
  localparam logic [8:0]  OVL_OK   = 9'(OVL_ALLOW_CYC);

  bfs_cmp_t   cmp;
  bfs_state_t state_reg;
  logic [6:0]  per_cnt_reg;
  logic        half_reg;
  logic        tick;
  logic        slow_reg;
  logic [8:0]  ovl_cnt_reg;
  logic [31:0] retry_cnt_reg;
  logic [15:0] ss_cnt_reg;
  logic        ovl_seen_reg;
  logic        retry_arm_reg;
  logic        hs_reg;
  logic        ls_reg;

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  // sync comparators
  bfs_sync #(
    .W      (CMP_W),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (cmp_in),
    .q    (cmp)
  );

  function automatic logic switching(input bfs_state_t s);
    return (s == BFS_SOFTSTART) || (s == BFS_RUN) || (s == BFS_RETRY_CHECK);
  endfunction

  // ---------------------------------------------------------------------------
  // Oscillator
  // ---------------------------------------------------------------------------
  // fixed period
  always_ff @(posedge clk)
  begin
    if (!rstn)
      per_cnt_reg <= '0;
    else if (per_cnt_reg == PER_LAST)
      per_cnt_reg <= '0;
    else
      per_cnt_reg <= per_cnt_reg + 7'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      half_reg <= 1'b0;
    else if (per_cnt_reg == PER_LAST)
      half_reg <= ~half_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      slow_reg <= 1'b0;
    else if (tick)
      slow_reg <= ovl_seen_reg && cmp.fb_low_fold;
  end

  // With halving, every second oscillator period is skipped entirely.
  assign tick = (per_cnt_reg == PER_LAST) && (!slow_reg || half_reg);

  // ---------------------------------------------------------------------------
  // Switch drive
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end
    else if (!switching(state_reg))
    begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end
    else if (tick)
    begin
      hs_reg <= 1'b1;
      ls_reg <= 1'b0;
    end
    else if (hs_reg && (cmp.over_limit || cmp.pk_reached))
    begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b1;
    end
    else if (ls_reg && cmp.ls_reverse)
      ls_reg <= 1'b0;
  end

  // Overload flag for the current period, cleared at each new period.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      ovl_seen_reg <= 1'b0;
    else if (cmp.over_limit && switching(state_reg))
      ovl_seen_reg <= 1'b1;
    else if (tick)
      ovl_seen_reg <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Overload counter
  // ---------------------------------------------------------------------------
  // overload tolerance
  always_ff @(posedge clk)
  begin
    if (!rstn)
      ovl_cnt_reg <= '0;
    else if (state_reg != BFS_RUN || !cmp.over_limit)
      ovl_cnt_reg <= '0;
    else if (ovl_cnt_reg != OVL_MAX)
      ovl_cnt_reg <= ovl_cnt_reg + 9'h001;
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg     <= BFS_SOFTSTART;
      ss_cnt_reg    <= '0;
      retry_cnt_reg <= '0;
      retry_arm_reg <= 1'b0;
    end
    else if (cmp.temp_hot && state_reg != BFS_THERMAL)
    begin
      state_reg <= BFS_THERMAL;
    end
    else
    begin
      case (state_reg)
        BFS_OFF:
          state_reg <= BFS_SOFTSTART;
        BFS_SOFTSTART:
        begin
          if (cmp.ss_at_start && tick)
            ss_cnt_reg <= ss_cnt_reg + 16'h0001;
          if (ss_cnt_reg == 16'(SS_PERIODS))
            state_reg <= retry_arm_reg ? BFS_RETRY_CHECK : BFS_RUN;
        end
        BFS_RUN:
        begin
          if (ovl_cnt_reg == OVL_MAX
              || (cmp.fb_short && cmp.over_limit && ovl_cnt_reg < OVL_OK))
          begin
            retry_arm_reg <= 1'b1;
            ss_cnt_reg    <= '0;
            state_reg     <= BFS_SOFTSTART;
          end
        end
        BFS_RETRY_CHECK:
        begin
          retry_arm_reg <= 1'b0;
          if (cmp.over_limit)
          begin
            retry_cnt_reg <= '0;
            state_reg     <= BFS_RETRY_OFF;
          end
          else if (tick)
            state_reg <= BFS_RUN;
        end
        BFS_RETRY_OFF:
        begin
          retry_cnt_reg <= retry_cnt_reg + 32'h0000_0001;
          if (retry_cnt_reg == 32'(RETRY_CYCLES - 1))
          begin
            ss_cnt_reg <= '0;
            state_reg  <= BFS_SOFTSTART;
          end
        end
        BFS_THERMAL:
        begin
          if (cmp.temp_cool && !cmp.temp_hot)
          begin
            ss_cnt_reg <= '0;
            state_reg  <= BFS_SOFTSTART;
          end
        end
        default:
          state_reg <= BFS_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      drive                  <= '0;
      ref_ramp               <= '0;
      ss_clamp               <= 1'b0;
      output_ok_flag_o       <= 1'b0;
      output_ok_flag_oe      <= 1'b1;
      burst_retry_protection <= 1'b0;
      thermal_off            <= 1'b0;
    end
    else
    begin
      drive.hs_on <= hs_reg;
      drive.ls_on <= ls_reg;
      if (state_reg != BFS_SOFTSTART)
        ref_ramp <= (state_reg == BFS_RETRY_OFF || state_reg == BFS_THERMAL) ? '0 : REF_FULL;
      else
        ref_ramp <= 10'((32'(ss_cnt_reg) * 32'(REF_FULL)) / 32'(SS_PERIODS));
      ss_clamp               <= (state_reg == BFS_RUN);
      output_ok_flag_o       <= 1'b0;
      output_ok_flag_oe      <= cmp.fb_low_ok || !switching(state_reg);
      burst_retry_protection <= (state_reg == BFS_RETRY_OFF) || retry_arm_reg;
      thermal_off            <= (state_reg == BFS_THERMAL);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_limit_cut;
    @(posedge clk) disable iff (!rstn)
      hs_reg && cmp.over_limit && !tick && switching(state_reg) |=> !hs_reg && ls_reg;
  endproperty
  a_limit_cut: assert property (p_limit_cut) else $error("High-side not cut at limit.");

  property p_no_early_retry;
    @(posedge clk) disable iff (!rstn)
      state_reg == BFS_RUN && ovl_cnt_reg < OVL_OK && !cmp.fb_short && !cmp.temp_hot
      |=> state_reg == BFS_RUN;
  endproperty
  a_no_early_retry: assert property (p_no_early_retry) else $error("Retry too early.");

  property p_long_ovl;
    @(posedge clk) disable iff (!rstn)
      state_reg == BFS_RUN && ovl_cnt_reg == OVL_MAX && !cmp.temp_hot |=> state_reg == BFS_SOFTSTART;
  endproperty
  a_long_ovl: assert property (p_long_ovl) else $error("Long overload ignored.");

  property p_short;
    @(posedge clk) disable iff (!rstn)
      state_reg == BFS_RUN && cmp.fb_short && cmp.over_limit && !cmp.temp_hot |=> retry_arm_reg;
  endproperty
  a_short: assert property (p_short) else $error("Short circuit not caught.");

  property p_ss_no_retry;
    @(posedge clk) disable iff (!rstn)
      state_reg == BFS_SOFTSTART |=> ovl_cnt_reg == 9'h000 && state_reg != BFS_RETRY_OFF;
  endproperty
  a_ss_no_retry: assert property (p_ss_no_retry) else $error("Retry during start-up.");

  property p_ok_low;
    @(posedge clk) disable iff (!rstn)
      cmp.fb_low_ok |=> output_ok_flag_oe && !output_ok_flag_o;
  endproperty
  a_ok_low: assert property (p_ok_low) else $error("Output-ok not pulled low.");

  property p_thermal;
    @(posedge clk) disable iff (!rstn)
      cmp.temp_hot |=> state_reg == BFS_THERMAL ##1 !hs_reg ##1 !drive.hs_on;
  endproperty
  a_thermal: assert property (p_thermal) else $error("Thermal stop missed.");

  property p_diode;
    @(posedge clk) disable iff (!rstn)
      ls_reg && cmp.ls_reverse && !tick && !(hs_reg && cmp.over_limit) |=> !ls_reg;
  endproperty
  a_diode: assert property (p_diode) else $error("Reverse current allowed.");

  c_retry_off: cover property (@(posedge clk) disable iff (!rstn) state_reg == BFS_RETRY_OFF);
  c_run:       cover property (@(posedge clk) disable iff (!rstn) state_reg == BFS_RUN);
  c_slow:      cover property (@(posedge clk) disable iff (!rstn) slow_reg);
  c_thermal:   cover property (@(posedge clk) disable iff (!rstn) thermal_off);

endmodule

// *** bfs_plant.sv ***
module bfs_plant
  import bfs_pkg::*;
(
  // Clock and switch commands
  input  wire logic                clk,
  input  wire bfs_pkg::bfs_drive_t drv,
  // Load and environment levels
  input  wire logic [7:0]          i_pk,
  input  wire logic [7:0]          current_limit_level,
  input  wire logic                ol_hold,
  input  wire logic [11:0]         fb_mv,
  input  wire logic                ss_up,
  input  wire logic [7:0]          temp_c,
  // Comparator outputs
  output bfs_pkg::bfs_cmp_t        cmp
);
  import bfs_pkg::*;
  logic [7:0] cur = 8'h00;

  // Current climbs while the high side conducts and decays otherwise.
  always_ff @(posedge clk)
  begin
    if (drv.hs_on)
      cur <= (cur > 8'hfb) ? 8'hff : cur + 8'h04;
    else
      cur <= (cur < 8'h02) ? 8'h00 : cur - 8'h02;
  end

  assign cmp.pk_reached  = cur >= i_pk;
  assign cmp.over_limit  = ol_hold | (cur >= current_limit_level);
  assign cmp.ls_reverse  = cur == 8'h00;
  assign cmp.fb_low_fold = fb_mv < 12'h2de;
  assign cmp.fb_short    = fb_mv < 12'h12c;
  assign cmp.fb_low_ok   = fb_mv < 12'h2d8;
  assign cmp.ss_at_start = ss_up;
  assign cmp.temp_hot    = temp_c > 8'h96;
  assign cmp.temp_cool   = temp_c <= 8'h82;
endmodule

// *** buck_fault_sequencer_tb_top.sv ***
module buck_fault_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bfs_pkg::*;
  // Short counts keep the run brief; retry stays longer than one period.
  localparam int RETRY = 120;
  localparam int SSP   = 4;
  logic       clk;
  logic       rstn;
  logic       ol_hold;
  logic       ss_up;
  logic [7:0] i_pk;
  logic [7:0] current_limit_level;
  logic [7:0] temp_c;
  logic [11:0] fb_mv;
  bfs_cmp_t   cmp;
  bfs_drive_t drv;
  logic [9:0] ref_ramp;
  logic       ss_clamp;
  logic       ok_o;
  logic       ok_oe;
  logic       ok_pin;
  logic       retry;
  logic       thermal_off;
  logic       hs;
  logic       ls;
  logic       cause;
  logic       zero;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         n;
  int         a;
  int         b;

  // The output-ok line has a pull-up.
  assign ok_pin = ok_oe ? ok_o : 1'b1;
  assign hs = drv.hs_on;
  assign ls = drv.ls_on;
  assign cause = cmp.pk_reached | cmp.over_limit;
  assign zero = cmp.ls_reverse;

  bfs_sequencer #(.RETRY_CYCLES(RETRY), .SS_PERIODS(SSP)) dut (
    .clk(clk), .rstn(rstn), .cmp_in(cmp), .drive(drv), .ref_ramp(ref_ramp),
    .ss_clamp(ss_clamp), .output_ok_flag_o(ok_o), .output_ok_flag_oe(ok_oe),
    .burst_retry_protection(retry), .thermal_off(thermal_off));

  bfs_plant plant (
    .clk(clk), .drv(drv), .i_pk(i_pk), .current_limit_level(current_limit_level), .ol_hold(ol_hold),
    .fb_mv(fb_mv), .ss_up(ss_up), .temp_c(temp_c), .cmp(cmp));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wait_v(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 1000)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic gap(output int g);
    int x;
    int y;
    wait_v(hs, 1'b0, x);
    wait_v(hs, 1'b1, x);
    wait_v(hs, 1'b0, x);
    wait_v(hs, 1'b1, y);
    g = x + y;
  endtask

  task automatic lat(output int p, output int q);
    int x;
    wait_v(hs, 1'b0, x);
    wait_v(hs, 1'b1, x);
    wait_v(cause, 1'b1, x);
    wait_v(hs, 1'b0, p);
    wait_v(zero, 1'b1, x);
    wait_v(ls, 1'b0, q);
  endtask

  task automatic off_run(input int span, output int m);
    int r;
    r = 0;
    m = 0;
    repeat (span)
    begin
      @(negedge clk);
      r = (hs === 1'b0) ? r + 1 : 0;
      m = (r > m) ? r : m;
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    ol_hold = 1'b0;
    ss_up = 1'b0;
    i_pk = 8'h28;
    current_limit_level = 8'hff;
    temp_c = 8'h19;
    fb_mv = 12'h320;
    step(8);
    chk("ok pin in reset", 0, ok_pin);
    rstn = 1'b1;
    ol_hold = 1'b1;
    step(300);
    chk("ref before start level", 0, ref_ramp);
    chk("retry in soft-start", 0, retry);
    ol_hold = 1'b0;
    ss_up = 1'b1;
    wait_v(ss_clamp, 1'b1, n);
    chk("ss_clamp", 1, ss_clamp);
    chk("ref at end", 10'h3ff, ref_ramp);
    gap(n);
    chk("period", SW_PERIOD_CYC, n);
    lat(a, b);
    chk("hs off delay", 1, a > 0 && a <= 4);
    chk("ls off delay", 1, b > 0 && b <= 4);
    fb_mv = 12'h2d7;
    step(8);
    chk("ok pin low", 0, ok_pin);
    fb_mv = 12'h2d8;
    step(8);
    chk("ok pin high", 1, ok_pin);
    fb_mv = 12'h320;
    current_limit_level = 8'h14;
    lat(a, b);
    chk("limit off delay", 1, a > 0 && a <= 4);
    gap(n);
    chk("period in limit", SW_PERIOD_CYC, n);
    current_limit_level = 8'hff;
    ol_hold = 1'b1;
    step(252);
    ol_hold = 1'b0;
    step(20);
    chk("retry after 252", 0, retry);
    ol_hold = 1'b1;
    wait_v(retry, 1'b1, n);
    chk("retry trip time", 1, n >= 257 && n <= 263);
    off_run(600, n);
    chk("retry off span", 1, n >= RETRY && n <= RETRY + SW_PERIOD_CYC + 8);
    ol_hold = 1'b0;
    wait_v(retry, 1'b0, n);
    chk("retry cleared", 0, retry);
    step(60);
    fb_mv = 12'h2bc;
    ol_hold = 1'b1;
    // Let the halving settle; the first period after overload may still be full rate.
    step(120);
    gap(n);
    chk("folded period", 2 * SW_PERIOD_CYC, n);
    ol_hold = 1'b0;
    fb_mv = 12'h320;
    wait_v(retry, 1'b0, n);
    step(60);
    fb_mv = 12'h0c8;
    ol_hold = 1'b1;
    wait_v(retry, 1'b1, n);
    chk("short trip time", 1, n <= 6);
    ol_hold = 1'b0;
    fb_mv = 12'h320;
    wait_v(retry, 1'b0, n);
    temp_c = 8'ha0;
    wait_v(thermal_off, 1'b1, n);
    chk("thermal trip time", 1, n <= 5);
    step(3);
    chk("drive when hot", 0, drv);
    temp_c = 8'h8c;
    step(20);
    chk("thermal hold", 1, thermal_off);
    temp_c = 8'h82;
    wait_v(thermal_off, 1'b0, n);
    chk("thermal resume time", 1, n <= 5);
    stop_test();
  end

  initial
  begin
    step(30000);
    mismatches++;
    stop_test();
  end
endmodule
